// file: bench/sppwm_load.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Pad loads
// ---------------------------------------------------------------
module sppwm_load (
   input  wire logic       clk_i,
   input  wire logic [3:0] pin_i,
   input  wire logic [3:0] oe_i,
   output logic      [3:0] pad_o
);
   // A known start lets a released pad toggle instead of holding unknown.
   logic [3:0] last_r = 4'h0;
   always_ff @(posedge clk_i) begin
      last_r <= pad_o;
   end
   // A released pad toggles, so a stale level can never pass for a drive.
   assign pad_o = (oe_i & pin_i) | (~oe_i & ~last_r);
endmodule : sppwm_load

// file: bench/sppwm_sva.sv
`timescale 1ns/1ps
module sppwm_sva (
   input wire logic                         clk_i,
   input wire logic                         rst_n_i,
   input wire logic                         sleep_i,
   input wire logic [sppwm_pkg::ADDR_W-1:0] avs_address_i,
   input wire logic                         avs_read_i,
   input wire logic                         avs_write_i,
   input wire logic [sppwm_pkg::DATA_W-1:0] avs_writedata_i,
   input wire logic [3:0]                   avs_byteenable_i,
   input wire logic [sppwm_pkg::DATA_W-1:0] avs_readdata_o,
   input wire logic                         avs_waitrequest_o,
   input wire logic [sppwm_pkg::NUM_CH-1:0] pin_o,
   input wire logic [sppwm_pkg::NUM_CH-1:0] pin_oe_o,
   input wire logic [sppwm_pkg::NUM_CH-1:0] wave_o
);
   import sppwm_pkg::*;
   logic req;
   logic tk;
   logic wr_ch0;
   assign req = avs_read_i | avs_write_i;
   assign tk = avs_write_i && !avs_waitrequest_o;
   assign wr_ch0 = tk && avs_byteenable_i[0] && avs_address_i == REG_CH_BASE
      && !avs_writedata_i[CC_EN_BIT];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // ---------------------------------------------------------------
   // Port relations
   // ---------------------------------------------------------------
   property p_wait;
      $rose(req) |-> avs_waitrequest_o ##1 !avs_waitrequest_o; endproperty
   a_wait: assert property (p_wait) else $error("wait");
   property p_rst;
      $rose(rst_n_i) |-> pin_oe_o == 4'h0 && wave_o == 4'h0; endproperty
   a_rst: assert property (p_rst) else $error("reset");
   property p_slp_w;
      $past(sleep_i) && $past(sleep_i, 2) |-> $stable(wave_o); endproperty
   a_slp_w: assert property (p_slp_w) else $error("sleep wave");
   property p_slp_p;
      $past(sleep_i) && $past(sleep_i, 2) |-> $stable({pin_o, pin_oe_o});
   endproperty
   a_slp_p: assert property (p_slp_p) else $error("sleep pin");
   property p_dis_lo;
      wr_ch0 && !avs_writedata_i[CC_INV_BIT] |-> ##3 !wave_o[0]; endproperty
   a_dis_lo: assert property (p_dis_lo) else $error("off low");
   property p_dis_hi;
      wr_ch0 && avs_writedata_i[CC_INV_BIT] |-> ##3 wave_o[0]; endproperty
   a_dis_hi: assert property (p_dis_hi) else $error("off high");
   property p_rd;
      $changed(avs_readdata_o) |-> $past(avs_read_i); endproperty
   a_rd: assert property (p_rd) else $error("read data");
   property p_oe;
      $changed(pin_oe_o) |-> $past(tk && avs_address_i == REG_PINDIR, 1)
         || $past(tk && avs_address_i == REG_PINDIR, 2); endproperty
   a_oe: assert property (p_oe) else $error("drive");
   c_rise: cover property ($rose(wave_o[0]));
   c_slp: cover property ($rose(sleep_i));
   c_rd: cover property (avs_read_i && !avs_waitrequest_o);
endmodule : sppwm_sva
bind sppwm_top sppwm_sva u_sva (
   .clk_i             (clk_i),
   .rst_n_i           (rst_n_i),
   .sleep_i           (sleep_i),
   .avs_address_i     (avs_address_i),
   .avs_read_i        (avs_read_i),
   .avs_write_i       (avs_write_i),
   .avs_writedata_i   (avs_writedata_i),
   .avs_byteenable_i  (avs_byteenable_i),
   .avs_readdata_o    (avs_readdata_o),
   .avs_waitrequest_o (avs_waitrequest_o),
   .pin_o             (pin_o),
   .pin_oe_o          (pin_oe_o),
   .wave_o            (wave_o)
);

// file: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
   import sppwm_pkg::*;
   logic              clk_i = 1'b0, rst_n_i = 1'b0, sleep_i = 1'b0;
   logic              avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic [ADDR_W-1:0] avs_address_i = 4'h0;
   logic [DATA_W-1:0] avs_writedata_i = 32'h0, avs_readdata_o, rd, v;
   logic [3:0]        avs_byteenable_i = 4'hF;
   logic              avs_waitrequest_o;
   logic [NUM_CH-1:0] pin_o, pin_oe_o, wave_o, pad, wv;
   logic [11:0]       run_r = 12'h000, len_r = 12'h000;
   logic [31:0]       dty [4] = '{32'h180, 32'h0, 32'h300, 32'h80};
   logic [31:0]       ctl [4] = '{32'hC0, 32'hC0, 32'hC0, 32'hD0};
   int                num_errors = 0, check_count = 0;
   sppwm_top uut (
      .clk_i             (clk_i),
      .rst_n_i           (rst_n_i),
      .sleep_i           (sleep_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .pin_o             (pin_o),
      .pin_oe_o          (pin_oe_o),
      .wave_o            (wave_o)
   );
   sppwm_load load (
      .clk_i (clk_i),
      .pin_i (pin_o),
      .oe_i  (pin_oe_o),
      .pad_o (pad)
   );
   always #50 clk_i = ~clk_i;
   always @(negedge clk_i) begin
      if (wave_o[0] === 1'b1) run_r <= run_r + 12'h001;
      else begin
         if (run_r != 12'h000) len_r <= run_r;
         run_r <= 12'h000;
      end
   end
   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic bus(logic w, logic [3:0] a, logic [31:0] d);
      @(posedge clk_i);
      avs_address_i <= a;
      avs_writedata_i <= d;
      avs_write_i <= w;
      avs_read_i <= !w;
      do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
      rd = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
   endtask : bus
   task automatic measure(int n, int e [6]);
      int c [6] = '{default: 0};
      logic w;
      @(negedge clk_i);
      w = wave_o[0];
      repeat (n) begin
         @(negedge clk_i);
         for (int i = 0; i < 4; i++) c[i] += int'(wave_o[i] === 1'b1);
         c[4] += int'(pad[0] === 1'b1);
         c[5] += int'(wave_o[0] === 1'b1 && w === 1'b0);
         w = wave_o[0];
      end
      for (int i = 0; i < 6; i++) check("count", c[i], e[i]);
   endtask : measure
   task automatic finish_test;
      if (num_errors == 0 && check_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      finish_test();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      check("oe", pin_oe_o, 4'h0);
      bus(1'b0, REG_PERIOD, 32'h0);
      check("per", rd, 32'h0000_00FF);
      bus(1'b0, REG_PINDIR, 32'h0);
      check("dir", rd, 32'h0000_000F);
      bus(1'b1, 4'h6, 32'h0000_00A5);
      bus(1'b0, 4'h6, 32'h0);
      check("gap", rd, 32'h0);
      bus(1'b1, REG_PINDIR, 32'h0000_000F);
      for (int i = 0; i < 4; i++) bus(1'b1, 4'(REG_CH_BASE + 2 * i), 32'h0);
      bus(1'b1, REG_PERIOD, 32'h0000_0003);
      for (int i = 0; i < 4; i++) bus(1'b1, 4'(9 + 2 * i), dty[i]);
      bus(1'b1, REG_FLAG, 32'h0000_0001);
      bus(1'b1, REG_TCTRL, 32'h0000_0004);
      do bus(1'b0, REG_FLAG, 32'h0); while (rd[0] !== 1'b1);
      bus(1'b1, REG_PINDIR, 32'h0);
      for (int i = 0; i < 4; i++) bus(1'b1, 4'(8 + 2 * i), ctl[i]);
      bus(1'b0, 4'h9, 32'h0);
      check("duty", rd, 32'h0000_0180);
      check("drive", pin_oe_o, 4'hF);
      repeat (20) @(posedge clk_i);
      measure(64, '{24, 0, 64, 56, 24, 4});
      bus(1'b0, 4'hC, 32'h0);
      check("ctl", rd, 32'h0000_00E0);
      sleep_i <= 1'b1;
      bus(1'b0, REG_COUNT, 32'h0);
      v = rd;
      wv = wave_o;
      repeat (20) @(posedge clk_i);
      bus(1'b0, REG_COUNT, 32'h0);
      check("cnt", rd, v);
      check("wave", wave_o, wv);
      sleep_i <= 1'b0;
      bus(1'b1, REG_PORTLAT, 32'h0000_0001);
      bus(1'b1, REG_CH_BASE, 32'h0000_0080);
      repeat (20) @(posedge clk_i);
      measure(64, '{24, 0, 64, 56, 64, 4});
      bus(1'b1, REG_TCTRL, 32'h0000_007D);
      repeat (70) @(posedge clk_i);
      measure(256, '{96, 0, 256, 224, 256, 4});
      bus(1'b1, REG_TCTRL, 32'h0000_0006);
      @(posedge wave_o[0]);
      bus(1'b1, 4'h9, 32'h0000_0100);
      @(negedge wave_o[0]);
      @(posedge clk_i);
      check("len", len_r, 12'h180);
      @(negedge wave_o[0]);
      @(posedge clk_i);
      check("len", len_r, 12'h100);
      bus(1'b1, REG_CH_BASE, 32'h0);
      bus(1'b1, REG_CH_BASE, 32'h0000_0010);
      bus(1'b1, 4'hE, 32'h0000_0010);
      measure(64, '{64, 0, 64, 64, 64, 0});
      bus(1'b0, REG_PORTLAT, 32'h0);
      check("lat", rd, 32'h0000_0001);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      @(negedge clk_i);
      check("rst", {pin_oe_o, wave_o}, 8'h00);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      bus(1'b0, REG_PERIOD, 32'h0);
      check("per", rd, 32'h0000_00FF);
      finish_test();
   end
endmodule : testbench

// file: pkg/sppwm_pkg.sv
package sppwm_pkg;

   // ---------------------------------------------------------------
   // Geometry
   // ---------------------------------------------------------------
   localparam int NUM_CH    = 4;
   localparam int ADDR_W    = 4;
   localparam int DATA_W    = 32;

   // ---------------------------------------------------------------
   // Register word offsets (byte address = 4 * index)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] REG_PERIOD   = 4'h0;
   localparam logic [ADDR_W-1:0] REG_TCTRL    = 4'h1;
   localparam logic [ADDR_W-1:0] REG_COUNT    = 4'h2;
   localparam logic [ADDR_W-1:0] REG_FLAG     = 4'h3;
   localparam logic [ADDR_W-1:0] REG_PINDIR   = 4'h4;
   localparam logic [ADDR_W-1:0] REG_PORTLAT  = 4'h5;
   localparam logic [ADDR_W-1:0] REG_CH_BASE  = 4'h8;
   localparam int                REG_CH_SHIFT = 1;

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int TC_RUN_BIT    = 2;
   localparam int CC_EN_BIT     = 7;
   localparam int CC_OE_BIT     = 6;
   localparam int CC_OUT_BIT    = 5;
   localparam int CC_INV_BIT    = 4;
   localparam int DL_LSB_POS    = 6;
   localparam int DH_POS        = 8;

   // ---------------------------------------------------------------
   // Reset values and prescale codes
   // ---------------------------------------------------------------
   localparam logic [7:0] PERIOD_RST = 8'hFF;
   localparam logic [3:0] PINDIR_RST = 4'hF;
   localparam logic [1:0] PS_DIV1    = 2'h0;
   localparam logic [1:0] PS_DIV4    = 2'h1;
   localparam logic [5:0] PS4_LAST   = 6'h03;
   localparam logic [5:0] PS64_LAST  = 6'h3F;

endpackage : sppwm_pkg

// file: rtl/sppwm_top.sv
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module sppwm_top (
   input  wire logic                          clk_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          sleep_i,
   input  wire logic [sppwm_pkg::ADDR_W-1:0]  avs_address_i,
   input  wire logic                          avs_read_i,
   input  wire logic                          avs_write_i,
   input  wire logic [sppwm_pkg::DATA_W-1:0]  avs_writedata_i,
   input  wire logic [3:0]                    avs_byteenable_i,
   output logic      [sppwm_pkg::DATA_W-1:0]  avs_readdata_o,
   output logic                               avs_waitrequest_o,
   output logic      [sppwm_pkg::NUM_CH-1:0]  pin_o,
   output logic      [sppwm_pkg::NUM_CH-1:0]  pin_oe_o,
   output logic      [sppwm_pkg::NUM_CH-1:0]  wave_o
);
   import sppwm_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]        period_match_value_r;
   logic              counter_run_r;
   logic [1:0]        prescale_select_r;
   logic [3:0]        postscale_r;
   logic [7:0]        period_counter_r;
   logic [5:0]        presc_r;
   logic [1:0]        sub_r;
   logic              period_match_flag_r;
   logic [NUM_CH-1:0] pin_direction_bit_r;
   logic [NUM_CH-1:0] port_latch_r;
   logic [NUM_CH-1:0] channel_enable_r;
   logic [NUM_CH-1:0] output_drive_enable_r;
   logic [NUM_CH-1:0] output_invert_r;
   logic [NUM_CH-1:0] state_r;
   logic [7:0]        duty_high_byte_r [NUM_CH];
   logic [1:0]        duty_low_bits_r  [NUM_CH];
   logic [9:0]        duty_buf_r       [NUM_CH];
   logic              ack_r;
   logic [DATA_W-1:0] rdata_r;

   function automatic logic is_ch(input logic [ADDR_W-1:0] a);
      return a >= REG_CH_BASE;
   endfunction : is_ch

   function automatic int ch_idx(input logic [ADDR_W-1:0] a);
      return int'((a - REG_CH_BASE) >> REG_CH_SHIFT);
   endfunction : ch_idx

   // ---------------------------------------------------------------
   // Time base
   // ---------------------------------------------------------------
   // Sleep gates every tick so the count resumes from where it stopped.
   logic       tick;
   logic       sub_wrap;
   logic       match;
   logic [9:0] time_base;
   logic       restart;
   logic [5:0] presc_last;

   always_comb begin
      case (prescale_select_r)
         PS_DIV1: presc_last = 6'h00;
         PS_DIV4: presc_last = PS4_LAST;
         default: presc_last = PS64_LAST;
      endcase
   end

   // A compare of at least the limit keeps a ratio that is lowered in
   // mid-count from running the prescaler out to its full 64 states.
   assign tick      = counter_run_r && !sleep_i
                      && (presc_r >= presc_last);
   assign sub_wrap  = tick && (sub_r == 2'h3);
   assign match     = (period_counter_r == period_match_value_r);
   assign restart   = sub_wrap && match;
   assign time_base = {period_counter_r, sub_r};

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         presc_r <= 6'h00;
      end else if (counter_run_r && !sleep_i) begin
         presc_r <= (presc_r >= presc_last) ? 6'h00 : presc_r + 6'h01;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sub_r <= 2'h0;
      end else if (tick) begin
         sub_r <= sub_r + 2'h1;
      end
   end

   // The postscaler is kept as storage only and never reaches the counter.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         period_counter_r <= 8'h00;
      end else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0]
                   && avs_address_i == REG_COUNT) begin
         period_counter_r <= avs_writedata_i[7:0];
      end else if (restart) begin
         period_counter_r <= 8'h00;
      end else if (sub_wrap) begin
         period_counter_r <= period_counter_r + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Channels
   // ---------------------------------------------------------------
   logic wr;
   assign wr = avs_write_i && !avs_waitrequest_o;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_CH; i++) begin
            duty_buf_r[i] <= 10'h000;
         end
      end else if (restart) begin
         for (int i = 0; i < NUM_CH; i++) begin
            duty_buf_r[i] <= {duty_high_byte_r[i],
                              duty_low_bits_r[i]};
         end
      end
   end

   // Compare uses the buffered duty so a half-written pair never glitches.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state_r <= '0;
      end else if (tick) begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (!channel_enable_r[i]) begin
               state_r[i] <= 1'b0;
            end else if (restart) begin
               state_r[i] <= ({duty_high_byte_r[i], duty_low_bits_r[i]}
                              != 10'h000);
            end else if ({duty_buf_r[i][9:2]} >= period_match_value_r
                         && duty_buf_r[i] != 10'h000) begin
               state_r[i] <= state_r[i];
            end else if (time_base + 10'h001 == duty_buf_r[i]) begin
               state_r[i] <= 1'b0;
            end
         end
      end else begin
         for (int i = 0; i < NUM_CH; i++) begin
            if (!channel_enable_r[i]) begin
               state_r[i] <= 1'b0;
            end
         end
      end
   end

   logic [NUM_CH-1:0] wave;
   assign wave = state_r ^ output_invert_r;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wave_o   <= '0;
         pin_o    <= '0;
         pin_oe_o <= '0;
      end else if (!sleep_i) begin
         wave_o   <= wave;
         for (int i = 0; i < NUM_CH; i++) begin
            pin_o[i] <= output_drive_enable_r[i] ? wave[i]
                        : port_latch_r[i];
         end
         pin_oe_o <= ~pin_direction_bit_r;
      end
   end

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         period_match_value_r <= PERIOD_RST;
         counter_run_r        <= 1'b0;
         prescale_select_r    <= PS_DIV1;
         postscale_r          <= 4'h0;
         pin_direction_bit_r  <= PINDIR_RST;
         port_latch_r         <= '0;
      end else if (wr && avs_byteenable_i[0]) begin
         if (avs_address_i == REG_PERIOD) begin
            period_match_value_r <= avs_writedata_i[7:0];
         end else if (avs_address_i == REG_TCTRL) begin
            counter_run_r     <= avs_writedata_i[TC_RUN_BIT];
            prescale_select_r <= avs_writedata_i[1:0];
            postscale_r       <= avs_writedata_i[6:3];
         end else if (avs_address_i == REG_PINDIR) begin
            pin_direction_bit_r <= avs_writedata_i[NUM_CH-1:0];
         end else if (avs_address_i == REG_PORTLAT) begin
            port_latch_r <= avs_writedata_i[NUM_CH-1:0];
         end
      end
   end

   // Set wins over a clear landing in the same cycle.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         period_match_flag_r <= 1'b0;
      end else if (restart) begin
         period_match_flag_r <= 1'b1;
      end else if (wr && avs_address_i == REG_FLAG
                   && avs_byteenable_i[0] && avs_writedata_i[0]) begin
         period_match_flag_r <= 1'b0;
      end
   end

   // Each channel owns two words: control then duty.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         channel_enable_r      <= '0;
         output_drive_enable_r <= '0;
         output_invert_r       <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            duty_high_byte_r[i] <= 8'h00;
            duty_low_bits_r[i]  <= 2'h0;
         end
      end else if (wr && is_ch(avs_address_i)) begin
         if (!avs_address_i[0] && avs_byteenable_i[0]) begin
            channel_enable_r[ch_idx(avs_address_i)] <=
               avs_writedata_i[CC_EN_BIT];
            output_drive_enable_r[ch_idx(avs_address_i)] <=
               avs_writedata_i[CC_OE_BIT];
            output_invert_r[ch_idx(avs_address_i)] <=
               avs_writedata_i[CC_INV_BIT];
         end else if (avs_address_i[0]) begin
            if (avs_byteenable_i[0]) begin
               duty_low_bits_r[ch_idx(avs_address_i)] <=
                  avs_writedata_i[DL_LSB_POS+:2];
            end
            if (avs_byteenable_i[1]) begin
               duty_high_byte_r[ch_idx(avs_address_i)] <=
                  avs_writedata_i[DH_POS+:8];
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus answer
   // ---------------------------------------------------------------
   // One wait cycle per access keeps read data registered.
   assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_r;
   assign avs_readdata_o    = rdata_r;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read_i || avs_write_i) && !ack_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_r <= '0;
      end else if (avs_read_i && !ack_r) begin
         rdata_r <= '0;
         if (avs_address_i == REG_PERIOD) begin
            rdata_r[7:0] <= period_match_value_r;
         end else if (avs_address_i == REG_TCTRL) begin
            rdata_r[6:0] <= {postscale_r, counter_run_r, prescale_select_r};
         end else if (avs_address_i == REG_COUNT) begin
            rdata_r[7:0] <= period_counter_r;
         end else if (avs_address_i == REG_FLAG) begin
            rdata_r[0] <= period_match_flag_r;
         end else if (avs_address_i == REG_PINDIR) begin
            rdata_r[NUM_CH-1:0] <= pin_direction_bit_r;
         end else if (avs_address_i == REG_PORTLAT) begin
            rdata_r[NUM_CH-1:0] <= port_latch_r;
         end else if (is_ch(avs_address_i) && !avs_address_i[0]) begin
            rdata_r[CC_EN_BIT]  <= channel_enable_r[ch_idx(avs_address_i)];
            rdata_r[CC_OE_BIT]  <=
               output_drive_enable_r[ch_idx(avs_address_i)];
            rdata_r[CC_OUT_BIT] <= wave[ch_idx(avs_address_i)];
            rdata_r[CC_INV_BIT] <= output_invert_r[ch_idx(avs_address_i)];
         end else if (is_ch(avs_address_i)) begin
            rdata_r[DH_POS+:8]     <= duty_high_byte_r[ch_idx(avs_address_i)];
            rdata_r[DL_LSB_POS+:2] <= duty_low_bits_r[ch_idx(avs_address_i)];
         end
      end
   end

endmodule : sppwm_top
